/* common/fallback_pkg.sv */
// Constants for the communication-loss output fallback block.
// Assumes one 100 MHz system clock and a word-wide register port.
package fallback_pkg;

    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned MS_NS         = 1000000;
    localparam int unsigned MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TICK_W        = 17;

    // Widths
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned RELAYS = 2;
    localparam int unsigned SUM_W  = 18;

    // Register offsets (register numbers)
    localparam logic [15:0] REG_RELAY_OUTPUTS      = 16'h0065;
    localparam logic [15:0] REG_COM_TIMEOUT        = 16'h006E;
    localparam logic [15:0] REG_RELAY_FAULT_ACTION = 16'h006F;
    localparam logic [15:0] REG_RELAY_FAULT_STATE  = 16'h0070;
    localparam logic [15:0] REG_RELAY_IDLE_ACTION  = 16'h0071;
    localparam logic [15:0] REG_RELAY_IDLE_STATE   = 16'h0072;
    localparam logic [15:0] REG_MOTOR_IDLE_HOLD    = 16'h00FB;
    localparam logic [15:0] REG_MOTOR_IDLE_VALUE   = 16'h00FC;
    localparam logic [15:0] REG_MOTOR_LOSS_HOLD    = 16'h00FD;
    localparam logic [15:0] REG_MOTOR_LOSS_VALUE   = 16'h00FE;
    localparam logic [15:0] REG_MOTOR_RUN_STATE    = 16'h012C;
    localparam logic [15:0] REG_PHASE_A_CURRENT    = 16'h012D;
    localparam logic [15:0] REG_PHASE_B_CURRENT    = 16'h012E;
    localparam logic [15:0] REG_PHASE_C_CURRENT    = 16'h012F;
    localparam logic [15:0] REG_AVERAGE_CURRENT    = 16'h0130;
    localparam logic [15:0] REG_THERMAL_LEVEL      = 16'h0131;

    // Values
    localparam logic [15:0] WORD_ZERO   = 16'h0000;
    localparam logic [15:0] MS_MAX      = 16'hFFFF;
    localparam logic [15:0] MS_ONE      = 16'h0001;
    localparam logic [15:0] ACT_IGNORE  = 16'h0000;
    localparam logic [15:0] ACT_STOP    = 16'h0001;
    localparam logic [1:0]  RELAY_ZERO  = 2'h0;
    localparam logic [17:0] DIVISOR     = 18'h00003;

endpackage

/* common/phase_avg_if.sv */
// Carrier between the top block and the phase-current averager.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface phase_avg_if;
    logic [15:0] phase_a;
    logic [15:0] phase_b;
    logic [15:0] phase_c;
    logic [15:0] average;

    modport source (output phase_a, output phase_b, output phase_c, input average);
    modport calc   (input phase_a, input phase_b, input phase_c, output average);
endinterface
`default_nettype wire

/* logic/comm_loss_output_fallback.sv */
// Fallback logic for two relay outputs and a motor controller on
// network idle or communication loss, with measurement readback.
// Assumes the register port and all inputs share sys_clk.
//
// Functional notes
// - Fault mask bit zero applies fault state
// - Fault state bit: zero off, one on
// - Idle mask bits chose per-relay idle behaviour
// - Idle mask zero drives idle state, one keeps
// - Idle state bit: zero off, one on
// - Idle hold flag true keeps motor unchanged
// - Idle action value one commands stop
// - Loss hold flag true keeps motor unchanged
// - Loss action value one commands stop
// - Thermal register reports percent, 100 trips
// - Average register is mean of phases
// - Timeout in ms declares fault; zero disables
`timescale 1ns/1ps
`default_nettype none
module comm_loss_output_fallback #(
    parameter int unsigned TICK_CYCLES = fallback_pkg::MS_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [15:0] bus_addr,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    input  wire logic [15:0] bus_wdata,
    input  wire logic        comm_idle,
    input  wire logic [15:0] motor_state_in,
    input  wire logic [15:0] phase_a_in,
    input  wire logic [15:0] phase_b_in,
    input  wire logic [15:0] phase_c_in,
    input  wire logic [15:0] thermal_in,
    output var  logic [15:0] bus_rdata,
    output var  logic        bus_rvalid,
    output var  logic [1:0]  relay_out,
    output var  logic        motor_stop,
    output var  logic        comm_fault
);
    localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

    // Configuration registers
    logic [15:0] relay_fault_action_mask;
    logic [15:0] relay_fault_state;
    logic [15:0] relay_idle_action_mask;
    logic [15:0] relay_idle_state;
    logic [15:0] motor_idle_hold_flag;
    logic [15:0] motor_idle_action_value;
    logic [15:0] motor_loss_hold_flag;
    logic [15:0] motor_loss_action_value;
    logic [15:0] com_timeout;
    logic [15:0] next_relay_fault_action_mask;
    logic [15:0] next_relay_fault_state;
    logic [15:0] next_relay_idle_action_mask;
    logic [15:0] next_relay_idle_state;
    logic [15:0] next_motor_idle_hold_flag;
    logic [15:0] next_motor_idle_action_value;
    logic [15:0] next_motor_loss_hold_flag;
    logic [15:0] next_motor_loss_action_value;
    logic [15:0] next_com_timeout;

    // Measurement captures
    logic [15:0] motor_run_state;
    logic [15:0] thermal_level;
    logic [15:0] next_motor_run_state;
    logic [15:0] next_thermal_level;
    logic [15:0] next_phase_a;
    logic [15:0] next_phase_b;
    logic [15:0] next_phase_c;

    // Timeout state
    logic [16:0] tick_cnt;
    logic [16:0] next_tick_cnt;
    logic [15:0] ms_cnt;
    logic [15:0] next_ms_cnt;
    logic        next_comm_fault;
    logic        ms_tick;
    logic        activity;

    // Events and outputs
    logic        idle_q;
    logic        idle_evt;
    logic        fault_evt;
    logic        wr_outputs;
    logic [1:0]  next_relay_out;
    logic [1:0]  next_relay_pick;
    logic        next_motor_stop;
    logic [15:0] next_bus_rdata;
    logic        next_bus_rvalid;

    phase_avg_if avg_bus ();

    phase_average u_phase_average (
        .sys_clk (sys_clk),
        .rst     (rst),
        .avg_bus (avg_bus)
    );

    // Any register access counts as network traffic
    assign activity   = bus_wr | bus_rd;
    assign wr_outputs = bus_wr && (bus_addr == fallback_pkg::REG_RELAY_OUTPUTS);
    assign ms_tick    = (tick_cnt == TICK_LAST);
    assign idle_evt   = comm_idle & ~idle_q;
    assign fault_evt  = next_comm_fault & ~comm_fault;

    // Register writes; read-only offsets silently ignore writes
    always_comb begin
        next_relay_fault_action_mask = relay_fault_action_mask;
        next_relay_fault_state       = relay_fault_state;
        next_relay_idle_action_mask  = relay_idle_action_mask;
        next_relay_idle_state        = relay_idle_state;
        next_motor_idle_hold_flag    = motor_idle_hold_flag;
        next_motor_idle_action_value = motor_idle_action_value;
        next_motor_loss_hold_flag    = motor_loss_hold_flag;
        next_motor_loss_action_value = motor_loss_action_value;
        next_com_timeout             = com_timeout;
        if (bus_wr) begin
            unique case (bus_addr)
                fallback_pkg::REG_RELAY_FAULT_ACTION: next_relay_fault_action_mask = bus_wdata;
                fallback_pkg::REG_RELAY_FAULT_STATE:  next_relay_fault_state       = bus_wdata;
                fallback_pkg::REG_RELAY_IDLE_ACTION:  next_relay_idle_action_mask  = bus_wdata;
                fallback_pkg::REG_RELAY_IDLE_STATE:   next_relay_idle_state        = bus_wdata;
                fallback_pkg::REG_MOTOR_IDLE_HOLD:    next_motor_idle_hold_flag    = bus_wdata;
                fallback_pkg::REG_MOTOR_IDLE_VALUE:   next_motor_idle_action_value = bus_wdata;
                fallback_pkg::REG_MOTOR_LOSS_HOLD:    next_motor_loss_hold_flag    = bus_wdata;
                fallback_pkg::REG_MOTOR_LOSS_VALUE:   next_motor_loss_action_value = bus_wdata;
                fallback_pkg::REG_COM_TIMEOUT:        next_com_timeout             = bus_wdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            relay_fault_action_mask <= fallback_pkg::WORD_ZERO;
            relay_fault_state       <= fallback_pkg::WORD_ZERO;
            relay_idle_action_mask  <= fallback_pkg::WORD_ZERO;
            relay_idle_state        <= fallback_pkg::WORD_ZERO;
            motor_idle_hold_flag    <= fallback_pkg::WORD_ZERO;
            motor_idle_action_value <= fallback_pkg::WORD_ZERO;
            motor_loss_hold_flag    <= fallback_pkg::WORD_ZERO;
            motor_loss_action_value <= fallback_pkg::WORD_ZERO;
            com_timeout             <= fallback_pkg::WORD_ZERO;
        end else begin
            relay_fault_action_mask <= next_relay_fault_action_mask;
            relay_fault_state       <= next_relay_fault_state;
            relay_idle_action_mask  <= next_relay_idle_action_mask;
            relay_idle_state        <= next_relay_idle_state;
            motor_idle_hold_flag    <= next_motor_idle_hold_flag;
            motor_idle_action_value <= next_motor_idle_action_value;
            motor_loss_hold_flag    <= next_motor_loss_hold_flag;
            motor_loss_action_value <= next_motor_loss_action_value;
            com_timeout             <= next_com_timeout;
        end
    end

    // Millisecond divider and idle-time counter, saturating at full scale
    always_comb begin
        next_tick_cnt = ms_tick ? 17'h00000 : tick_cnt + 17'h00001;
        next_ms_cnt   = ms_cnt;
        if (activity) begin
            next_ms_cnt = fallback_pkg::WORD_ZERO;
        end else if (ms_tick && (ms_cnt != fallback_pkg::MS_MAX)) begin
            next_ms_cnt = ms_cnt + fallback_pkg::MS_ONE;
        end
        // Zero timeout disables detection; traffic clears the fault
        next_comm_fault = !activity && (com_timeout != fallback_pkg::WORD_ZERO)
                          && (ms_cnt >= com_timeout);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tick_cnt   <= 17'h00000;
            ms_cnt     <= fallback_pkg::WORD_ZERO;
            comm_fault <= 1'b0;
            idle_q     <= 1'b0;
        end else begin
            tick_cnt   <= next_tick_cnt;
            ms_cnt     <= next_ms_cnt;
            comm_fault <= next_comm_fault;
            idle_q     <= comm_idle;
        end
    end

    // Per-relay fallback; fault outranks idle, both outrank a client write
    for (genvar i = 0; i < fallback_pkg::RELAYS; i++) begin : g_relay
        always_comb begin
            if (fault_evt && !relay_fault_action_mask[i]) begin
                next_relay_pick[i] = relay_fault_state[i];
            end else if (idle_evt && !relay_idle_action_mask[i]) begin
                next_relay_pick[i] = relay_idle_state[i];
            end else if (wr_outputs) begin
                next_relay_pick[i] = bus_wdata[i];
            end else begin
                next_relay_pick[i] = relay_out[i];
            end
        end
    end

    // Motor stop pulse; only value one means stop, anything else ignores
    always_comb begin
        next_relay_out  = next_relay_pick;
        next_motor_stop = (idle_evt && (motor_idle_hold_flag == fallback_pkg::WORD_ZERO)
                           && (motor_idle_action_value == fallback_pkg::ACT_STOP))
                       || (fault_evt && (motor_loss_hold_flag == fallback_pkg::WORD_ZERO)
                           && (motor_loss_action_value == fallback_pkg::ACT_STOP));
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            relay_out  <= fallback_pkg::RELAY_ZERO;
            motor_stop <= 1'b0;
        end else begin
            relay_out  <= next_relay_out;
            motor_stop <= next_motor_stop;
        end
    end

    // Measurement capture every cycle; the averager trails by one cycle
    always_comb begin
        next_motor_run_state = motor_state_in;
        next_thermal_level   = thermal_in;
        next_phase_a         = phase_a_in;
        next_phase_b         = phase_b_in;
        next_phase_c         = phase_c_in;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            motor_run_state <= fallback_pkg::WORD_ZERO;
            thermal_level   <= fallback_pkg::WORD_ZERO;
            avg_bus.phase_a <= fallback_pkg::WORD_ZERO;
            avg_bus.phase_b <= fallback_pkg::WORD_ZERO;
            avg_bus.phase_c <= fallback_pkg::WORD_ZERO;
        end else begin
            motor_run_state <= next_motor_run_state;
            thermal_level   <= next_thermal_level;
            avg_bus.phase_a <= next_phase_a;
            avg_bus.phase_b <= next_phase_b;
            avg_bus.phase_c <= next_phase_c;
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        next_bus_rvalid = bus_rd;
        next_bus_rdata  = fallback_pkg::WORD_ZERO;
        if (bus_rd) begin
            unique case (bus_addr)
                fallback_pkg::REG_RELAY_OUTPUTS:      next_bus_rdata = {14'h0000, relay_out};
                fallback_pkg::REG_COM_TIMEOUT:        next_bus_rdata = com_timeout;
                fallback_pkg::REG_RELAY_FAULT_ACTION: next_bus_rdata = relay_fault_action_mask;
                fallback_pkg::REG_RELAY_FAULT_STATE:  next_bus_rdata = relay_fault_state;
                fallback_pkg::REG_RELAY_IDLE_ACTION:  next_bus_rdata = relay_idle_action_mask;
                fallback_pkg::REG_RELAY_IDLE_STATE:   next_bus_rdata = relay_idle_state;
                fallback_pkg::REG_MOTOR_IDLE_HOLD:    next_bus_rdata = motor_idle_hold_flag;
                fallback_pkg::REG_MOTOR_IDLE_VALUE:   next_bus_rdata = motor_idle_action_value;
                fallback_pkg::REG_MOTOR_LOSS_HOLD:    next_bus_rdata = motor_loss_hold_flag;
                fallback_pkg::REG_MOTOR_LOSS_VALUE:   next_bus_rdata = motor_loss_action_value;
                fallback_pkg::REG_MOTOR_RUN_STATE:    next_bus_rdata = motor_run_state;
                fallback_pkg::REG_PHASE_A_CURRENT:    next_bus_rdata = avg_bus.phase_a;
                fallback_pkg::REG_PHASE_B_CURRENT:    next_bus_rdata = avg_bus.phase_b;
                fallback_pkg::REG_PHASE_C_CURRENT:    next_bus_rdata = avg_bus.phase_c;
                fallback_pkg::REG_AVERAGE_CURRENT:    next_bus_rdata = avg_bus.average;
                fallback_pkg::REG_THERMAL_LEVEL:      next_bus_rdata = thermal_level;
                default:                              next_bus_rdata = fallback_pkg::WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bus_rdata  <= fallback_pkg::WORD_ZERO;
            bus_rvalid <= 1'b0;
        end else begin
            bus_rdata  <= next_bus_rdata;
            bus_rvalid <= next_bus_rvalid;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_FAULT_APPLY: assert property (
        fault_evt && !relay_fault_action_mask[0] |=> relay_out[0] == $past(relay_fault_state[0])
    ) else $error("fault state not applied to relay one");
    AST_FAULT_KEEP: assert property (
        fault_evt && relay_fault_action_mask[1] && !(idle_evt && !relay_idle_action_mask[1])
        && !wr_outputs |=> $stable(relay_out[1])
    ) else $error("masked relay two changed on fault");
    AST_FAULT_ON: assert property (
        fault_evt && !relay_fault_action_mask[1] && relay_fault_state[1] |=> relay_out[1]
    ) else $error("fault state one did not turn relay on");
    AST_IDLE_APPLY: assert property (
        idle_evt && !fault_evt && !relay_idle_action_mask[0]
        |=> relay_out[0] == $past(relay_idle_state[0])
    ) else $error("idle state not applied to relay one");
    AST_IDLE_SPLIT: assert property (
        idle_evt && !fault_evt && !wr_outputs && relay_idle_action_mask[0]
        && !relay_idle_action_mask[1]
        |=> $stable(relay_out[0]) && relay_out[1] == $past(relay_idle_state[1])
    ) else $error("idle mask bits not independent");
    AST_IDLE_OFF: assert property (
        idle_evt && !fault_evt && !relay_idle_action_mask[1] && !relay_idle_state[1]
        |=> !relay_out[1]
    ) else $error("idle state zero did not turn relay off");
    AST_MOTOR_IDLE_HOLD: assert property (
        idle_evt && !fault_evt && (|motor_idle_hold_flag) |=> !motor_stop
    ) else $error("motor stopped although idle hold set");
    AST_MOTOR_IDLE_STOP: assert property (
        idle_evt && (motor_idle_hold_flag == fallback_pkg::WORD_ZERO)
        && (motor_idle_action_value == fallback_pkg::ACT_STOP) |=> motor_stop ##1 !motor_stop
    ) else $error("idle stop not commanded as one pulse");
    AST_MOTOR_LOSS_HOLD: assert property (
        fault_evt && !idle_evt && (|motor_loss_hold_flag) |=> !motor_stop
    ) else $error("motor stopped although loss hold set");
    AST_MOTOR_LOSS_STOP: assert property (
        fault_evt && (motor_loss_hold_flag == fallback_pkg::WORD_ZERO)
        && (motor_loss_action_value == fallback_pkg::ACT_STOP) |=> motor_stop
    ) else $error("loss stop not commanded");
    AST_THERMAL_READ: assert property (
        bus_rd && bus_addr == fallback_pkg::REG_THERMAL_LEVEL
        |=> bus_rvalid && bus_rdata == $past(thermal_in, 2)
    ) else $error("thermal read does not match input");
    AST_TIMEOUT_FAULT: assert property (
        !activity && com_timeout != fallback_pkg::WORD_ZERO && ms_cnt >= com_timeout |=> comm_fault
    ) else $error("fault not declared after timeout");
    AST_TIMEOUT_OFF: assert property (
        com_timeout == fallback_pkg::WORD_ZERO |=> !comm_fault
    ) else $error("fault declared with detection disabled");
    AST_RECOVER_KEEP: assert property (
        comm_fault && activity && !wr_outputs && !idle_evt |=> $stable(relay_out) && !comm_fault
    ) else $error("relays changed on recovery");
endmodule // comm_loss_output_fallback
`default_nettype wire

/* logic/phase_average.sv */
// Registered mean of the three scaled phase currents.
// Assumes the phase words are already registered by the caller.
`timescale 1ns/1ps
`default_nettype none
module phase_average (
    input  wire logic  sys_clk,
    input  wire logic  rst,
    phase_avg_if.calc  avg_bus
);
    logic [17:0] sum;
    logic [17:0] quotient;
    logic [15:0] average;
    logic [15:0] next_average;
    logic [17:0] avg_times3;

    // Widened sum so three full-scale words cannot overflow
    always_comb begin
        sum = {2'b00, avg_bus.phase_a} + {2'b00, avg_bus.phase_b} + {2'b00, avg_bus.phase_c};
        quotient = sum / fallback_pkg::DIVISOR;
        next_average = quotient[15:0];
    end

    // Result register, one cycle behind the phase words
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            average <= fallback_pkg::WORD_ZERO;
        end else begin
            average <= next_average;
        end
    end

    assign avg_bus.average = average;

    // Check helper: average scaled back up towards the sum
    assign avg_times3 = {2'b00, average} * fallback_pkg::DIVISOR;

    // Floor mean: scaled average sits within one divisor step below the sum
    AST_AVERAGE: assert property (@(posedge sys_clk) disable iff (rst)
        $stable(avg_bus.phase_a) && $stable(avg_bus.phase_b) && $stable(avg_bus.phase_c)
        |-> avg_times3 <= sum && (sum - avg_times3) < fallback_pkg::DIVISOR
    ) else $error("average is not mean of phases");
endmodule // phase_average
`default_nettype wire

/* verification/net_client.sv */
// Network client model: issues single register writes and reads.
// Assumes strobes are sampled on the rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module net_client (
    input  wire logic        sys_clk,
    input  wire logic [15:0] bus_rdata,
    input  wire logic        bus_rvalid,
    output var  logic [15:0] bus_addr,
    output var  logic        bus_wr,
    output var  logic        bus_rd,
    output var  logic [15:0] bus_wdata
);
    // Quiet bus at time zero
    initial begin
        bus_addr = 16'h0000;
        bus_wdata = 16'h0000;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    end

    // Data inverted once released, so stale words never look valid
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk) #1;
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(posedge sys_clk) #1;
        bus_wr = 1'b0;
        bus_wdata = ~d;
    endtask

    // Answer is registered, so it is taken one edge after the strobe
    task automatic rd(input logic [15:0] a, output logic [15:0] q, output logic v);
        @(posedge sys_clk) #1;
        bus_addr = a;
        bus_rd = 1'b1;
        @(posedge sys_clk) #1;
        bus_rd = 1'b0;
        q = bus_rdata;
        v = bus_rvalid;
    endtask
endmodule // net_client
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the communication-loss fallback block.
// Assumes the client model owns the register port, one access at a time.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int TICK = 10;
    localparam logic [15:0] RW[8] = '{16'h006F, 16'h0070, 16'h0071, 16'h0072,
                                      16'h00FB, 16'h00FC, 16'h00FD, 16'h00FE};
    logic        sys_clk, rst, comm_idle, bus_wr, bus_rd, bus_rvalid;
    logic        motor_stop, comm_fault, v, stop;
    logic [15:0] bus_addr, bus_wdata, bus_rdata, motor_state_in, thermal_in, q;
    logic [15:0] ph[3];
    logic [1:0]  relay_out;
    int          n_errors, checked, rel, k, m, s, h, a;
    int          shadow[8];
    logic [3:0]  outs, want;
    assign outs = {comm_fault, motor_stop, relay_out};

    comm_loss_output_fallback #(.TICK_CYCLES(TICK)) dut (.sys_clk(sys_clk), .rst(rst),
        .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
        .comm_idle(comm_idle), .motor_state_in(motor_state_in), .phase_a_in(ph[0]),
        .phase_b_in(ph[1]), .phase_c_in(ph[2]), .thermal_in(thermal_in),
        .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .relay_out(relay_out),
        .motor_stop(motor_stop), .comm_fault(comm_fault));
    net_client cli (.sys_clk(sys_clk), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
        .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata));

    task automatic final_report;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk_rd(input logic [15:0] ad, input int e);
        cli.rd(ad, q, v);
        checked++;
        if (v !== 1'b1 || q !== 16'(e)) begin
            n_errors++;
            $display("wrong value at %0t: read %h got %h", $time, ad, q);
        end
    endtask

    // Packed as fault, stop, relay two, relay one
    task automatic chk_out(input logic [3:0] g, input logic [3:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: outputs %b expected %b", $time, g, e);
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Whole run is a few hundred cycles
    initial begin
        #200000;
        n_errors++;
        final_report();
    end

    initial begin
        k = $urandom(32'hBB0E248C);
        rst = 1'b1;
        comm_idle = 1'b0;
        motor_state_in = 16'($urandom % 5);
        thermal_in = 16'($urandom % 101);
        foreach (ph[i]) ph[i] = 16'($urandom);
        repeat (2) @(posedge sys_clk);
        #1 rst = 1'b0;
        // Words read back as written; the thermal word ignores a write
        foreach (RW[i]) begin
            shadow[i] = $urandom % 65536;
            cli.wr(RW[i], 16'(shadow[i]));
        end
        foreach (RW[i]) chk_rd(RW[i], shadow[i]);
        cli.wr(16'h0131, 16'hFFFF);
        chk_rd(16'h012C, motor_state_in);
        for (k = 0; k < 3; k++) chk_rd(16'(16'h012D + k), ph[k]);
        chk_rd(16'h0130, (int'(ph[0]) + int'(ph[1]) + int'(ph[2])) / 3);
        chk_rd(16'h0131, thermal_in);
        chk_rd(16'h0200, 0);
        $display("test registers done");
        // Idle event per mask, state and motor setting
        for (k = 0; k < 8; k++) begin
            m = k % 4;
            s = $urandom % 4;
            h = (k % 4 == 3) ? 1 + $urandom % 2 : 0;
            a = (k % 4 == 1) ? $urandom % 2 * 2 : 1;
            rel = $urandom % 4;
            cli.wr(16'h0065, 16'(rel));
            cli.wr(16'h0071, 16'(m));
            cli.wr(16'h0072, 16'(s));
            cli.wr(16'h00FB, 16'(h));
            cli.wr(16'h00FC, 16'(a));
            @(posedge sys_clk) #1 comm_idle = 1'b1;
            @(posedge sys_clk) #1;
            rel = (rel & m) | (s & ~m & 3);
            want = {1'b0, 1'(h == 0 && a == 1), 2'(rel)};
            chk_out(outs, want);
            @(posedge sys_clk) #1 comm_idle = 1'b0;
            chk_out({comm_fault, motor_stop, relay_out}, {2'b00, 2'(rel)});
        end
        $display("test idle done");
        // Timeout fault for every fault mask, then recovery by a read
        for (m = 0; m < 4; m++) begin
            s = $urandom % 4;
            h = (m == 3) ? 1 + $urandom % 2 : 0;
            a = (m == 1) ? $urandom % 2 * 2 : 1;
            rel = $urandom % 4;
            cli.wr(16'h0065, 16'(rel));
            cli.wr(16'h006F, 16'(m));
            cli.wr(16'h0070, 16'(s));
            cli.wr(16'h00FD, 16'(h));
            cli.wr(16'h00FE, 16'(a));
            cli.wr(16'h006E, 16'h0002);
            for (k = 0; k < 100 && comm_fault !== 1'b1; k++) @(posedge sys_clk) #1;
            stop = motor_stop;
            @(posedge sys_clk) #1;
            stop = stop | motor_stop;
            rel = (rel & m) | (s & ~m & 3);
            want = {1'b1, 1'(h == 0 && a == 1), 2'(rel)};
            chk_out({comm_fault, stop, relay_out}, want);
            chk_out({3'b000, 1'(k >= TICK && k <= 2 * TICK + 3)}, 4'b0001);
            chk_rd(16'h0070, s);
            @(posedge sys_clk) #1;
            chk_out({comm_fault, motor_stop, relay_out}, {2'b00, 2'(rel)});
        end
        cli.wr(16'h006E, 16'h0000);
        repeat (40) @(posedge sys_clk);
        chk_out({comm_fault, 3'b000}, 4'b0000);
        $display("test fault done");
        final_report();
    end
endmodule // testbench
`default_nettype wire
